//--- src/cms_obj_timer.sv
// Purpose: Event period and inhibit timing of one transmit object
// Assumes: One ms tick pulse per millisecond
// Notes: Disabling clears all timing state
`timescale 1ns/1ps
module cms_obj_timer
   import cms_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  ms_tick,
   input  wire logic                  enable,
   input  wire logic [CMS_TIME_W-1:0] period,
   input  wire logic [CMS_TIME_W-1:0] inhibit,
   input  wire logic                  sent,
   output logic                       due_r
);
   logic [CMS_TIME_W-1:0] ev_cnt_r, ev_cnt_nxt;
   logic [CMS_TIME_W-1:0] inh_cnt_r, inh_cnt_nxt;
   logic                  pend_r, pend_nxt;
   logic                  due_nxt;
   logic                  fire;

   always_comb begin
      fire        = enable && (period != '0) && ms_tick && (ev_cnt_r + 16'h0001 >= period);
      ev_cnt_nxt  = ev_cnt_r;
      inh_cnt_nxt = inh_cnt_r;
      pend_nxt    = pend_r;
      if (!enable) begin
         ev_cnt_nxt  = '0;
         inh_cnt_nxt = '0;
         pend_nxt    = 1'b0;
      end else begin
         if (ms_tick) begin
            ev_cnt_nxt = fire ? '0 : ev_cnt_r + 16'h0001;
         end
         if (ms_tick && inh_cnt_r != '0) begin
            inh_cnt_nxt = inh_cnt_r - 16'h0001;
         end
         if (sent) begin
            pend_nxt    = 1'b0;
            inh_cnt_nxt = inhibit;
         end
         if (fire) begin
            pend_nxt = 1'b1;
         end
      end
      due_nxt = pend_nxt && (inh_cnt_nxt == '0);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ev_cnt_r  <= '0;
         inh_cnt_r <= '0;
         pend_r    <= 1'b0;
         due_r     <= 1'b0;
      end else begin
         ev_cnt_r  <= ev_cnt_nxt;
         inh_cnt_r <= inh_cnt_nxt;
         pend_r    <= pend_nxt;
         due_r     <= due_nxt;
      end
   end

   a_zero_period_quiet : assert property (@(posedge core_clk) disable iff (rst)
      (period == '0) && $stable(period) && !pend_r |=> !pend_r)
      else $error("object with zero period became pending");

   a_inhibit_blocks : assert property (@(posedge core_clk) disable iff (rst)
      sent && enable && (inhibit != '0) |=> !due_r)
      else $error("object due inside its inhibit time");
endmodule : cms_obj_timer

//--- src/cms_pkg.sv
// Purpose: Shared types and constants of the message scheduler
// Assumes: 40 MHz core clock, synchronous active-high reset
// Notes: Constants and carrier types only
package cms_pkg;
   localparam int          CMS_OBJ_NUM      = 4;
   localparam int          CMS_ID_W         = 11;
   localparam int          CMS_TIME_W       = 16;
   localparam int          CMS_CLK_PERIOD_PS = 25000;
   localparam int          CMS_MS_PS        = 1000000000;
   localparam int          CMS_MS_CYCLES    = CMS_MS_PS / CMS_CLK_PERIOD_PS;
   localparam logic [3:0][10:0] CMS_OBJ_OFS = {11'h480, 11'h380, 11'h280, 11'h180};
   localparam logic [3:1][10:0] CMS_ADD_OFS = {11'h300, 11'h200, 11'h100};
   localparam logic [7:0]  CMS_CAN_TYPE     = 8'h00;

   typedef enum logic {CMS_FMT_CAN, CMS_FMT_OPEN} cms_fmt_type;
   typedef enum logic {CMS_IDLE, CMS_OFFER} cms_state_type;

   typedef struct packed {
      logic [CMS_TIME_W-1:0] event_ms;
      logic [CMS_TIME_W-1:0] inhibit_ms;
      logic [7:0]            tx_type;
   } cms_obj_type;

   typedef struct packed {
      cms_fmt_type                   fmt;
      logic [2:0]                    baud_sel;
      logic [6:0]                    node_id;
      cms_obj_type [CMS_OBJ_NUM-1:0] obj;
      logic [CMS_ID_W-1:0]           main_telegram_identifier;
      logic [CMS_ID_W-1:0]           listen_identifier;
      logic [CMS_TIME_W-1:0]         out_time_ms;
   } cms_cfg_type;

   typedef struct packed {
      logic [1:0]          obj;
      logic [CMS_ID_W-1:0] id;
      logic [7:0]          tx_type;
   } cms_tx_type;

   localparam cms_cfg_type CMS_CFG_RST = '0;
endpackage : cms_pkg

//--- src/cms_scheduler.sv
// Purpose: Identifier assignment and transmit scheduling for the field-bus port
// Assumes: Config and receive inputs synchronous to core_clk
// Notes: Saved config is taken only at reset release or on restart
`timescale 1ns/1ps
module cms_scheduler
   import cms_pkg::*;
#(
   parameter int MS_CYCLES = CMS_MS_CYCLES
)(
   input  wire logic                           core_clk,
   input  wire logic                           rst,
   input  cms_cfg_type                         cfg_saved,
   input  wire logic                           restart_req,
   input  wire logic                           tx_ready,
   input  wire logic                           rx_valid,
   input  wire logic [CMS_ID_W-1:0]            rx_id,
   output logic                                tx_valid_r,
   output cms_tx_type                          tx_req_r,
   output logic [2:0]                          baud_sel_r,
   output cms_fmt_type                         bus_format_r,
   output logic [3:1][CMS_ID_W-1:0]            extra_id_r,
   output logic                                rx_accept_r,
   output logic                                cfg_applied_r
);
   cms_cfg_type   act_r, act_nxt;
   logic          load_r, load_nxt;
   logic [31:0]   ms_cnt_r, ms_cnt_nxt;
   logic          tick_r, tick_nxt;
   cms_state_type state_r, state_nxt;
   logic          tx_valid_nxt;
   cms_tx_type    tx_req_nxt;
   logic [2:0]    baud_sel_nxt;
   cms_fmt_type   bus_format_nxt;
   logic [3:1][CMS_ID_W-1:0] extra_id_nxt;
   logic          rx_accept_nxt;
   logic          cfg_applied_nxt;

   logic [CMS_OBJ_NUM-1:0]                 due;
   logic [CMS_OBJ_NUM-1:0]                 sent;
   logic [CMS_OBJ_NUM-1:0]                 obj_en;
   logic [CMS_OBJ_NUM-1:0][CMS_TIME_W-1:0] obj_period;
   logic [CMS_OBJ_NUM-1:0][CMS_TIME_W-1:0] obj_inhibit;
   logic [CMS_OBJ_NUM-1:0][CMS_ID_W-1:0]   obj_id;
   logic [CMS_OBJ_NUM-1:0][7:0]            obj_type;

   // Active config held until restart
   always_comb begin
      act_nxt         = act_r;
      load_nxt        = load_r;
      cfg_applied_nxt = 1'b0;
      if (load_r) begin
         act_nxt         = cfg_saved;
         load_nxt        = 1'b0;
         cfg_applied_nxt = 1'b1;
      end
      if (restart_req) begin
         load_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         act_r         <= CMS_CFG_RST;
         load_r        <= 1'b1;
         cfg_applied_r <= 1'b0;
      end else begin
         act_r         <= act_nxt;
         load_r        <= load_nxt;
         cfg_applied_r <= cfg_applied_nxt;
      end
   end

   // Millisecond tick
   always_comb begin
      tick_nxt   = 1'b0;
      ms_cnt_nxt = ms_cnt_r + 32'h00000001;
      if (ms_cnt_r >= 32'(MS_CYCLES - 1)) begin
         ms_cnt_nxt = '0;
         tick_nxt   = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ms_cnt_r <= '0;
         tick_r   <= 1'b0;
      end else begin
         ms_cnt_r <= ms_cnt_nxt;
         tick_r   <= tick_nxt;
      end
   end

   // Per-object identifiers and timing
   for (genvar i = 0; i < CMS_OBJ_NUM; i++) begin : g_obj
      always_comb begin
         if (act_r.fmt == CMS_FMT_OPEN) begin
            obj_en[i]      = !load_r;
            obj_period[i]  = act_r.obj[i].event_ms;
            obj_inhibit[i] = act_r.obj[i].inhibit_ms;
            obj_id[i]      = {4'h0, act_r.node_id} + CMS_OBJ_OFS[i];
            obj_type[i]    = act_r.obj[i].tx_type;
         end else begin
            obj_en[i]      = !load_r && (i == 0);
            obj_period[i]  = (i == 0) ? act_r.out_time_ms : '0;
            obj_inhibit[i] = '0;
            obj_id[i]      = act_r.main_telegram_identifier;
            obj_type[i]    = CMS_CAN_TYPE;
         end
      end

      cms_obj_timer u_timer (
         .core_clk (core_clk),
         .rst      (rst),
         .ms_tick  (tick_r),
         .enable   (obj_en[i]),
         .period   (obj_period[i]),
         .inhibit  (obj_inhibit[i]),
         .sent     (sent[i]),
         .due_r    (due[i])
      );
   end

   // Transmit offer, lowest object first
   always_comb begin
      state_nxt    = state_r;
      tx_valid_nxt = tx_valid_r;
      tx_req_nxt   = tx_req_r;
      sent         = '0;
      case (state_r)
         CMS_IDLE: begin
            if (!load_r) begin
               for (int k = CMS_OBJ_NUM - 1; k >= 0; k--) begin
                  if (due[k]) begin
                     sent               = '0;
                     sent[k]            = 1'b1;
                     tx_req_nxt.obj     = 2'(k);
                     tx_req_nxt.id      = obj_id[k];
                     tx_req_nxt.tx_type = obj_type[k];
                     tx_valid_nxt       = 1'b1;
                     state_nxt          = CMS_OFFER;
                  end
               end
            end
         end
         CMS_OFFER: begin
            if (tx_ready || load_r) begin
               tx_valid_nxt = 1'b0;
               state_nxt    = CMS_IDLE;
            end
         end
         default: begin
            tx_valid_nxt = 1'b0;
            state_nxt    = CMS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r    <= CMS_IDLE;
         tx_valid_r <= 1'b0;
         tx_req_r   <= '0;
      end else begin
         state_r    <= state_nxt;
         tx_valid_r <= tx_valid_nxt;
         tx_req_r   <= tx_req_nxt;
      end
   end

   // Link settings, extra identifiers, receive filter
   always_comb begin
      baud_sel_nxt   = act_r.baud_sel;
      bus_format_nxt = act_r.fmt;
      for (int k = 1; k <= 3; k++) begin
         extra_id_nxt[k] = act_r.main_telegram_identifier + CMS_ADD_OFS[k];
      end
      rx_accept_nxt = rx_valid && (act_r.fmt == CMS_FMT_CAN) && !load_r &&
                      (rx_id == act_r.listen_identifier);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         baud_sel_r   <= '0;
         bus_format_r <= CMS_FMT_CAN;
         extra_id_r   <= '0;
         rx_accept_r  <= 1'b0;
      end else begin
         baud_sel_r   <= baud_sel_nxt;
         bus_format_r <= bus_format_nxt;
         extra_id_r   <= extra_id_nxt;
         rx_accept_r  <= rx_accept_nxt;
      end
   end

   // Checks
   sequence s_restart;
      restart_req ##1 load_r;
   endsequence

   a_restart_apply : assert property (@(posedge core_clk) disable iff (rst)
      s_restart |=> (act_r == $past(cfg_saved)) && cfg_applied_r)
      else $error("saved config not applied after restart");

   a_config_held : assert property (@(posedge core_clk) disable iff (rst)
      $changed(act_r) |-> $past(load_r))
      else $error("active config changed without restart");

   a_tpdo_ident : assert property (@(posedge core_clk) disable iff (rst)
      $rose(tx_valid_r) && act_r.fmt == CMS_FMT_OPEN |->
         tx_req_r.id == {4'h0, act_r.node_id} + CMS_OBJ_OFS[tx_req_r.obj])
      else $error("profile identifier not node plus offset");

   a_main_ident : assert property (@(posedge core_clk) disable iff (rst)
      $rose(tx_valid_r) && act_r.fmt == CMS_FMT_CAN |->
         tx_req_r.obj == 2'h0 && tx_req_r.id == act_r.main_telegram_identifier)
      else $error("plain telegram on wrong identifier or object");

   a_tpdo_type : assert property (@(posedge core_clk) disable iff (rst)
      $rose(tx_valid_r) && act_r.fmt == CMS_FMT_OPEN |-> tx_req_r.tx_type == act_r.obj[tx_req_r.obj].tx_type)
      else $error("transmission type not carried");

   a_extra_ident : assert property (@(posedge core_clk) disable iff (rst)
      !load_r |=> extra_id_r[2] == act_r.main_telegram_identifier + 11'h200 &&
         extra_id_r[1] == act_r.main_telegram_identifier + 11'h100 &&
         extra_id_r[3] == act_r.main_telegram_identifier + 11'h300)
      else $error("extra identifier mismatch");

   a_listen_accept : assert property (@(posedge core_clk) disable iff (rst)
      rx_valid && !load_r && act_r.fmt == CMS_FMT_CAN && rx_id == act_r.listen_identifier |=> rx_accept_r)
      else $error("frame on listen identifier not accepted");

   a_listen_reject : assert property (@(posedge core_clk) disable iff (rst)
      act_r.fmt == CMS_FMT_OPEN |=> !rx_accept_r)
      else $error("frame accepted in profile format");

   a_baud_follow : assert property (@(posedge core_clk) disable iff (rst)
      ##1 baud_sel_r == $past(act_r.baud_sel))
      else $error("bit rate select not from active config");

   a_offer_hold : assert property (@(posedge core_clk) disable iff (rst)
      tx_valid_r && !tx_ready && !load_r |=> tx_valid_r && $stable(tx_req_r))
      else $error("offer withdrawn before taken");
endmodule : cms_scheduler

//--- testbench/cms_can_peer.sv
// Purpose: Far-side CAN controller model for the scheduler
// Assumes: Offers taken on tx_valid_r && tx_ready at core_clk
// Notes: Slow mode raises ready only every fourth cycle
`timescale 1ns/1ps
module cms_can_peer
   import cms_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                slow,
   output logic                     tx_ready,
   output logic                     rx_valid,
   output logic [CMS_ID_W-1:0]      rx_id
);
   logic [1:0] cnt_r;

   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_id    = 11'h000;
      cnt_r    = 2'h0;
   end

   // Ready pacing, prompt or slow
   always @(posedge core_clk) begin
      cnt_r    <= rst ? 2'h0 : cnt_r + 2'h1;
      tx_ready <= rst ? 1'b0 : (slow ? (cnt_r == 2'h3) : 1'b1);
   end

   // One received frame; identifier inverted once the frame is gone
   task automatic send_frame(input logic [CMS_ID_W-1:0] id);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_id    <= id;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_id    <= ~id;
   endtask : send_frame
endmodule : cms_can_peer

//--- testbench/tb_top.sv
// Purpose: Self-checking bench of the message scheduler
// Assumes: 40 MHz core_clk, ms tick shortened to 8 cycles
// Notes: Offers are logged by a monitor and judged per scenario
`timescale 1ns/1ps
module tb_top;
   import cms_pkg::*;
   localparam int MS = 8;
   logic                       core_clk;
   logic                       rst;
   logic                       restart_req;
   logic                       slow;
   cms_cfg_type                cfg_saved;
   logic                       tx_ready;
   logic                       rx_valid;
   logic [CMS_ID_W-1:0]        rx_id;
   logic                       tx_valid_r;
   cms_tx_type                 tx_req_r;
   logic [2:0]                 baud_sel_r;
   cms_fmt_type                bus_format_r;
   logic [3:1][CMS_ID_W-1:0]   extra_id_r;
   logic                       rx_accept_r;
   logic                       cfg_applied_r;
   int                         n_fail;
   int                         n_compared;
   int                         cyc;
   int                         t_q[$];
   cms_tx_type                 req_q[$];
   logic                       prev_pend;
   cms_tx_type                 prev_req;

   cms_scheduler #(.MS_CYCLES(MS)) dut (.core_clk(core_clk), .rst(rst), .cfg_saved(cfg_saved),
      .restart_req(restart_req), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id),
      .tx_valid_r(tx_valid_r), .tx_req_r(tx_req_r), .baud_sel_r(baud_sel_r), .bus_format_r(bus_format_r),
      .extra_id_r(extra_id_r), .rx_accept_r(rx_accept_r), .cfg_applied_r(cfg_applied_r));

   cms_can_peer u_peer (.core_clk(core_clk), .rst(rst), .slow(slow), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_id(rx_id));

   always #12.5 core_clk = ~core_clk;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic results;
      $display("Comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   // Offer log and hold check while an offer stands
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         results();
      end
      if (!rst && prev_pend && tx_valid_r === 1'b1) chk("tx_req_hold", prev_req, tx_req_r);
      prev_pend = !rst && tx_valid_r === 1'b1 && tx_ready !== 1'b1;
      prev_req  = tx_req_r;
      if (!rst && tx_valid_r === 1'b1 && tx_ready === 1'b1) begin
         t_q.push_back(cyc);
         req_q.push_back(tx_req_r);
      end
   end

   task automatic wait_applied;
      int k;
      for (k = 0; k < 100 && cfg_applied_r !== 1'b1; k++) @(posedge core_clk) #1;
      chk("cfg_applied_seen", 1, cfg_applied_r);
      repeat (2) @(posedge core_clk);
      #1;
   endtask : wait_applied

   task automatic rx_try(input logic [10:0] id, input logic exp);
      u_peer.send_frame(id);
      #1 chk("rx_accept", exp, rx_accept_r);
      @(posedge core_clk) #1 chk("rx_accept_end", 0, rx_accept_r);
   endtask : rx_try

   task automatic sc_plain;
      int i;
      wait_applied();
      chk("baud", 3'h5, baud_sel_r);
      chk("format", CMS_FMT_CAN, bus_format_r);
      chk("extra1", 11'h050, extra_id_r[1]);
      chk("extra2", 11'h150, extra_id_r[2]);
      chk("extra3", 11'h250, extra_id_r[3]);
      t_q.delete();
      req_q.delete();
      repeat (14 * MS) @(posedge core_clk);
      chk("plain_sends", 1, t_q.size() >= 3);
      for (i = 0; i < t_q.size(); i++) begin
         chk("plain_id", 11'h750, req_q[i].id);
         chk("plain_type", 8'h00, req_q[i].tx_type);
         if (i > 0) chk("plain_gap", 3 * MS, t_q[i] - t_q[i-1]);
      end
   endtask : sc_plain

   task automatic sc_rx;
      rx_try(11'h201, 1'b1);
      rx_try(11'h202, 1'b0);
      rx_try(11'h201, 1'b1);
   endtask : sc_rx

   task automatic sc_restart;
      @(posedge core_clk);
      cfg_saved.fmt    <= CMS_FMT_OPEN;
      cfg_saved.baud_sel <= 3'h2;
      cfg_saved.node_id <= 7'h05;
      cfg_saved.obj[0] <= '{16'h0002, 16'h0000, 8'hFF};
      cfg_saved.obj[1] <= '{16'h0003, 16'h0006, 8'h01};
      cfg_saved.obj[2] <= '{16'h0000, 16'h0000, 8'h02};
      cfg_saved.obj[3] <= '{16'h0005, 16'h0000, 8'hFE};
      repeat (40) @(posedge core_clk);
      #1 chk("old_format", CMS_FMT_CAN, bus_format_r);
      chk("old_baud", 3'h5, baud_sel_r);
      chk("old_extra", 11'h050, extra_id_r[1]);
      @(posedge core_clk) restart_req <= 1'b1;
      @(posedge core_clk) restart_req <= 1'b0;
      #1 chk("applied_early", 0, cfg_applied_r);
      @(posedge core_clk) #1 chk("applied_pulse", 1, cfg_applied_r);
      @(posedge core_clk) #1 chk("applied_end", 0, cfg_applied_r);
      @(posedge core_clk);
      #1 chk("new_format", CMS_FMT_OPEN, bus_format_r);
      chk("new_baud", 3'h2, baud_sel_r);
      rx_try(11'h201, 1'b0);
   endtask : sc_restart

   task automatic sc_profile;
      logic [10:0] ofs [4];
      logic [7:0]  typ [4];
      int          cnt [4];
      int          last1;
      int          i;
      ofs = '{11'h180, 11'h280, 11'h380, 11'h480};
      typ = '{8'hFF, 8'h01, 8'h02, 8'hFE};
      cnt = '{0, 0, 0, 0};
      last1 = -1000;
      t_q.delete();
      req_q.delete();
      @(posedge core_clk);
      slow <= 1'b1;
      repeat (40 * MS) @(posedge core_clk);
      for (i = 0; i < t_q.size(); i++) begin
         cnt[req_q[i].obj]++;
         chk("obj_id", 11'h005 + ofs[req_q[i].obj], req_q[i].id);
         chk("obj_type", typ[req_q[i].obj], req_q[i].tx_type);
         if (req_q[i].obj == 2'h1) begin
            chk("inhibit_gap", 1, t_q[i] - last1 >= 5 * MS);
            last1 = t_q[i];
         end
      end
      chk("obj0_count", 1, cnt[0] >= 10);
      chk("obj1_count", 1, cnt[1] >= 3);
      chk("obj2_count", 0, cnt[2]);
      chk("obj3_count", 1, cnt[3] >= 3);
   endtask : sc_profile

   initial begin
      core_clk    = 1'b0;
      rst         = 1'b1;
      restart_req = 1'b0;
      slow        = 1'b0;
      n_fail      = 0;
      n_compared  = 0;
      cyc         = 0;
      prev_pend   = 1'b0;
      cfg_saved   = CMS_CFG_RST;
      cfg_saved.fmt = CMS_FMT_CAN;
      cfg_saved.baud_sel = 3'h5;
      cfg_saved.main_telegram_identifier = 11'h750;
      cfg_saved.listen_identifier = 11'h201;
      cfg_saved.out_time_ms = 16'h0003;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      sc_plain();
      sc_rx();
      sc_restart();
      sc_profile();
      results();
   end
endmodule : tb_top
